/* File: bpd_pkg.sv */
// constants for the general-purpose bidirectional port block
// assumes an apb slave with 32-bit data and byte addresses
package bpd_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] BPD_P0C_GDIR_IDX = 8'h27;
  localparam logic [7:0] BPD_P1A_DIR_IDX = 8'h35;
  localparam logic [7:0] BPD_P0B_DIR_IDX = 8'h36;
  localparam logic [7:0] BPD_P0A_DIR_IDX = 8'h37;
  localparam logic [7:0] BPD_P0A_DAT_IDX = 8'h40;
  localparam logic [7:0] BPD_P0B_DAT_IDX = 8'h41;
  localparam logic [7:0] BPD_P0C_DAT_IDX = 8'h42;
  localparam logic [7:0] BPD_P1A_DAT_IDX = 8'h43;
  localparam logic [7:0] BPD_CTRL_IDX = 8'h44;
  // field positions
  localparam int BPD_GDIR_BIT = 0;
  localparam int BPD_CTRL_CE_BIT = 0;
  localparam int BPD_CTRL_STOP_BIT = 1;
  localparam int BPD_CTRL_HALT_BIT = 2;
  localparam int BPD_RMW_LO = 2;
  // values after reset
  localparam logic [3:0] BPD_DIR_RST = 4'h0;
  localparam logic [2:0] BPD_CTRL_RST = 3'h0;
  localparam logic [31:0] BPD_RDATA_RST = 32'h0000_0000;

  function automatic logic [9:0] bpd_addr(input logic [7:0] idx);
    bpd_addr = {idx, 2'b00};
  endfunction : bpd_addr
endpackage : bpd_pkg

/* File: bpd_port.sv */
// bidirectional port logic for ports 0a, 0b, 0c and 1a behind apb
// assumes pins come from outside ref_clk and are synchronised here
//
// How it works
// - port 1a per-pin direction register
// - port 0c group direction, bit 0 only
// - reset, ce reset, stop clear directions
// - input pins are not driven
// - input pin read returns pin level
// - writes update latch in input mode
// - output pins drive latch, input releases
// - one drives high, zero drives low
// - output pins read back the latch
// - port 0a bits 3:2 read pin level
// - latches not reset, kept over ce/stop
// - halt blocks port writes, ce reset and stop still clear directions
// - stop gates inputs except port 0c
// - ports 0a, 0b, 1a per-pin direction
// - 0a direction 37h, 0b at 36h
`timescale 1ns/10ps
module bpd_port
  import bpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] portZeroAIn,
  output logic [3:0] portZeroAOut,
  output logic [3:0] portZeroAOe,
  input wire logic [3:0] portZeroBIn,
  output logic [3:0] portZeroBOut,
  output logic [3:0] portZeroBOe,
  input wire logic [3:0] portZeroCIn,
  output logic [3:0] portZeroCOut,
  output logic [3:0] portZeroCOe,
  input wire logic [3:0] portOneAIn,
  output logic [3:0] portOneAOut,
  output logic [3:0] portOneAOe,
  output logic inputGate
);
  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic access;
  logic wrEn;
  logic inRange;
  logic [9:0] wordAddr;
  // acts in the first access cycle only, pready closes it
  assign access = psel & penable & ~pready;
  // nothing is mapped above the low 1 kbyte
  assign inRange = paddr[11:10] == 2'h0;
  assign wrEn = access & pwrite & inRange;
  // aligned byte address, compared against bpd_addr()
  assign wordAddr = {paddr[9:2], 2'b00};

  // true when the aligned address names register idx
  function automatic logic isReg(input logic [9:0] addr,
                                 input logic [7:0] idx);
    isReg = addr == bpd_addr(idx);
  endfunction : isReg

  // drive value of a port: latch where the pin is an output
  function automatic logic [3:0] driveVal(input logic [3:0] lat,
                                          input logic [3:0] dir);
    driveVal = lat & dir;
  endfunction : driveVal

  logic [3:0] portZeroADirection_q;
  logic [3:0] portZeroBDirection_q;
  logic portZeroCGroupDirection_q;
  logic [3:0] portOneADirection_q;
  logic [3:0] latchZeroA_q;
  logic [3:0] latchZeroB_q;
  logic [3:0] latchZeroC_q;
  logic [3:0] latchOneA_q;
  logic [2:0] ctrl_q;
  logic ceReset;
  logic clockStop;
  logic halted;
  assign ceReset = ctrl_q[BPD_CTRL_CE_BIT];
  assign clockStop = ctrl_q[BPD_CTRL_STOP_BIT];
  assign halted = ctrl_q[BPD_CTRL_HALT_BIT];

  // ****************************************************************
  // write selects
  // ****************************************************************
  logic wrOpen;
  logic dirClear;
  logic wrCtrl;
  logic wrDirZeroA;
  logic wrDirZeroB;
  logic wrDirZeroC;
  logic wrDirOneA;
  logic wrDatZeroA;
  logic wrDatZeroB;
  logic wrDatZeroC;
  logic wrDatOneA;
  // halt blocks port writes, control stays open
  assign wrOpen = wrEn & ~halted;
  // ce reset and stop hold directions clear
  assign dirClear = ceReset | clockStop;
  assign wrCtrl = wrEn & isReg(wordAddr, BPD_CTRL_IDX);
  assign wrDirZeroA = wrOpen & isReg(wordAddr, BPD_P0A_DIR_IDX);
  assign wrDirZeroB = wrOpen & isReg(wordAddr, BPD_P0B_DIR_IDX);
  assign wrDirZeroC = wrOpen & isReg(wordAddr, BPD_P0C_GDIR_IDX);
  assign wrDirOneA = wrOpen & isReg(wordAddr, BPD_P1A_DIR_IDX);
  assign wrDatZeroA = wrOpen & isReg(wordAddr, BPD_P0A_DAT_IDX);
  assign wrDatZeroB = wrOpen & isReg(wordAddr, BPD_P0B_DAT_IDX);
  assign wrDatZeroC = wrOpen & isReg(wordAddr, BPD_P0C_DAT_IDX);
  assign wrDatOneA = wrOpen & isReg(wordAddr, BPD_P1A_DAT_IDX);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [15:0] pinMeta_q;
  logic [15:0] pinSync_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q <= 16'h0000;
      pinSync_q <= 16'h0000;
    end else begin
      pinMeta_q <= {portOneAIn, portZeroCIn, portZeroBIn, portZeroAIn};
      pinSync_q <= pinMeta_q;
    end
  end

  // buffers gated in stop, port 0c open
  logic [3:0] pinZeroA;
  logic [3:0] pinZeroB;
  logic [3:0] pinZeroC;
  logic [3:0] pinOneA;
  assign pinZeroA = clockStop ? 4'h0 : pinSync_q[3:0];
  assign pinZeroB = clockStop ? 4'h0 : pinSync_q[7:4];
  assign pinZeroC = pinSync_q[11:8];
  assign pinOneA = clockStop ? 4'h0 : pinSync_q[15:12];

  // input reads pin, output reads latch
  function automatic logic [3:0] readMix(input logic [3:0] dir,
                                         input logic [3:0] lat,
                                         input logic [3:0] pin);
    readMix = (dir & lat) | (~dir & pin);
  endfunction : readMix

  logic [3:0] readZeroA;
  always_comb begin
    readZeroA = readMix(portZeroADirection_q, latchZeroA_q, pinZeroA);
    // top two bits always show pin level
    readZeroA[3:BPD_RMW_LO] = pinZeroA[3:BPD_RMW_LO];
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= BPD_CTRL_RST;
    end else if (wrCtrl) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // ****************************************************************
  // direction registers
  // ****************************************************************
  // power-on, ce and stop clear directions
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroADirection_q <= BPD_DIR_RST;
    end else if (dirClear) begin
      portZeroADirection_q <= BPD_DIR_RST;
    end else if (wrDirZeroA) begin
      portZeroADirection_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroBDirection_q <= BPD_DIR_RST;
    end else if (dirClear) begin
      portZeroBDirection_q <= BPD_DIR_RST;
    end else if (wrDirZeroB) begin
      portZeroBDirection_q <= pwdata[3:0];
    end
  end

  // one group bit for port 0c
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroCGroupDirection_q <= BPD_DIR_RST[BPD_GDIR_BIT];
    end else if (dirClear) begin
      portZeroCGroupDirection_q <= BPD_DIR_RST[BPD_GDIR_BIT];
    end else if (wrDirZeroC) begin
      portZeroCGroupDirection_q <= pwdata[BPD_GDIR_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portOneADirection_q <= BPD_DIR_RST;
    end else if (dirClear) begin
      portOneADirection_q <= BPD_DIR_RST;
    end else if (wrDirOneA) begin
      portOneADirection_q <= pwdata[3:0];
    end
  end

  // ****************************************************************
  // output latches
  // ****************************************************************
  // no reset term, kept over ce and stop
  always_ff @(posedge ref_clk) begin
    if (wrDatZeroA) begin
      latchZeroA_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrDatZeroB) begin
      latchZeroB_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrDatZeroC) begin
      latchZeroC_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wrDatOneA) begin
      latchOneA_q <= pwdata[3:0];
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  logic [3:0] groupC;
  assign groupC = {4{portZeroCGroupDirection_q}};
  // drive latch when output, release when input
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroAOe <= 4'h0;
      portZeroAOut <= 4'h0;
    end else begin
      portZeroAOe <= portZeroADirection_q;
      portZeroAOut <= driveVal(latchZeroA_q, portZeroADirection_q);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroBOe <= 4'h0;
      portZeroBOut <= 4'h0;
    end else begin
      portZeroBOe <= portZeroBDirection_q;
      portZeroBOut <= driveVal(latchZeroB_q, portZeroBDirection_q);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portZeroCOe <= 4'h0;
      portZeroCOut <= 4'h0;
    end else begin
      portZeroCOe <= groupC;
      portZeroCOut <= driveVal(latchZeroC_q, groupC);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      portOneAOe <= 4'h0;
      portOneAOut <= 4'h0;
    end else begin
      portOneAOe <= portOneADirection_q;
      portOneAOut <= driveVal(latchOneA_q, portOneADirection_q);
    end
  end

  // gate flag follows the stop bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      inputGate <= 1'b0;
    end else begin
      inputGate <= clockStop;
    end
  end

  // ****************************************************************
  // read data and handshake
  // ****************************************************************
  logic [31:0] rdNext;
  logic hit;
  always_comb begin
    rdNext = BPD_RDATA_RST;
    hit = 1'b1;
    unique case (wordAddr)
      bpd_addr(BPD_P0A_DIR_IDX): rdNext[3:0] = portZeroADirection_q;
      bpd_addr(BPD_P0B_DIR_IDX): rdNext[3:0] = portZeroBDirection_q;
      bpd_addr(BPD_P0C_GDIR_IDX): begin
        rdNext[BPD_GDIR_BIT] = portZeroCGroupDirection_q;
      end
      bpd_addr(BPD_P1A_DIR_IDX): rdNext[3:0] = portOneADirection_q;
      bpd_addr(BPD_P0A_DAT_IDX): rdNext[3:0] = readZeroA;
      bpd_addr(BPD_P0B_DAT_IDX): begin
        rdNext[3:0] = readMix(portZeroBDirection_q, latchZeroB_q, pinZeroB);
      end
      bpd_addr(BPD_P0C_DAT_IDX): rdNext[3:0] = readMix(groupC,
                                                       latchZeroC_q, pinZeroC);
      bpd_addr(BPD_P1A_DAT_IDX): begin
        rdNext[3:0] = readMix(portOneADirection_q, latchOneA_q, pinOneA);
      end
      bpd_addr(BPD_CTRL_IDX): rdNext[2:0] = ctrl_q;
      default: hit = 1'b0;
    endcase
    // the low 1 kbyte is not repeated above it
    if (!inRange) begin
      hit = 1'b0;
      rdNext = BPD_RDATA_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= BPD_RDATA_RST;
    end else begin
      pready <= access;
      pslverr <= access & ~hit;
      if (access && !pwrite) begin
        prdata <= rdNext;
      end
    end
  end
endmodule : bpd_port

/* File: bpd_port_sva.sv */
// assertion checker for the port block on its top-level ports
// assumes one apb request outstanding at a time
`timescale 1ns/10ps
module bpd_port_sva
  import bpd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] portOneAOut,
  input wire logic [3:0] portOneAOe,
  input wire logic [3:0] portZeroCOe,
  input wire logic inputGate
);
  logic [2:0] ctrl_q;
  logic [7:0] idx;
  logic mapped;
  logic ctrlWr;
  assign idx = paddr[9:2];
  assign mapped = paddr[11:10] == 2'h0 && idx inside {BPD_P0C_GDIR_IDX,
    [BPD_P1A_DIR_IDX:BPD_P0A_DIR_IDX], [BPD_P0A_DAT_IDX:BPD_CTRL_IDX]};
  assign ctrlWr = pready && pwrite && mapped && idx == BPD_CTRL_IDX;
  // control bits as left by completed writes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) ctrl_q <= BPD_CTRL_RST;
    else if (ctrlWr) ctrl_q <= pwdata[2:0];
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("bad pslverr");
  a_dir_write: assert property (pready && pwrite && ctrl_q == 3'h0
    && mapped && idx == BPD_P1A_DIR_IDX |=> portOneAOe == $past(pwdata[3:0]))
    else $error("direction not written");
  a_group_dir: assert property (portZeroCOe inside {4'h0, 4'hf})
    else $error("split group direction");
  a_reset_dirs: assert property (ctrl_q[1:0] != 2'h0
    |-> ##2 portOneAOe == 4'h0 && portZeroCOe == 4'h0)
    else $error("direction not cleared");
  a_gate_stop: assert property (ctrl_q[1] && !ctrlWr |-> inputGate)
    else $error("input gate low");
  a_halt_hold: assert property (ctrl_q == 3'h4
    |=> $stable(portOneAOe) && $stable(portOneAOut))
    else $error("state changed in halt");
  a_in_released: assert property (ctrl_q[0] |-> ##2 portOneAOut == 4'h0)
    else $error("input pin driven");
endmodule : bpd_port_sva

/* File: bpd_board.sv */
// board model for one 4-bit port pin group
// assumes oe high while the block drives the pin
`timescale 1ns/10ps
module bpd_board (
  input wire logic [3:0] out,
  input wire logic [3:0] oe,
  input wire logic [3:0] drv,
  input wire logic [3:0] lo,
  output logic [3:0] pin
);
  assign pin = ((oe & out) | (~oe & drv)) & ~lo;
endmodule : bpd_board

/* File: bpd_port_test.sv */
// self-checking bench for the port block, registers reached over apb
// assumes a board model on each port resolving pin levels
`timescale 1ns/10ps
module bpd_port_test
  import bpd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, inputGate;
  logic [3:0] portZeroAIn, portZeroAOut, portZeroAOe, portZeroBIn;
  logic [3:0] portZeroBOut, portZeroBOe, portZeroCIn, portZeroCOut;
  logic [3:0] portZeroCOe, portOneAIn, portOneAOut, portOneAOe;
  logic [3:0] aLow = 4'h0;
  logic [3:0] bLow = 4'h0;
  logic [3:0] dLow = 4'h0;
  logic [15:0] oes, outs;
  logic [7:0] dirIdx [4] = '{BPD_P0A_DIR_IDX, BPD_P0B_DIR_IDX,
    BPD_P1A_DIR_IDX, BPD_P0C_GDIR_IDX};
  int failures = 0;
  int testsRun = 0;
  assign oes = {portZeroAOe, portZeroBOe, portZeroCOe, portOneAOe};
  assign outs = {portZeroAOut, portZeroBOut, portZeroCOut, portOneAOut};
  bpd_port uut (.*);
  bpd_board brdA (.out(portZeroAOut), .oe(portZeroAOe), .drv(4'h9),
    .lo(aLow), .pin(portZeroAIn));
  bpd_board brdB (.out(portZeroBOut), .oe(portZeroBOe), .drv(4'h3),
    .lo(bLow), .pin(portZeroBIn));
  bpd_board brdC (.out(portZeroCOut), .oe(portZeroCOe), .drv(4'h5),
    .lo(4'h0), .pin(portZeroCIn));
  bpd_board brdD (.out(portOneAOut), .oe(portOneAOe), .drv(4'h9),
    .lo(dLow), .pin(portOneAIn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] idx,
    input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic pause();
    repeat (4) @(posedge ref_clk);
  endtask : pause
  task automatic final_report();
    if (failures == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (dirIdx[i]) rd(dirIdx[i], 32'h0);
    wr(BPD_P0A_DAT_IDX, 32'hf);
    wr(BPD_P0B_DAT_IDX, 32'h6);
    wr(BPD_P0C_DAT_IDX, 32'ha);
    wr(BPD_P1A_DAT_IDX, 32'h6);
    foreach (dirIdx[i]) begin
      wr(dirIdx[i], 32'hffff_ffff);
      rd(dirIdx[i], (i == 3) ? 32'h1 : 32'hf);
    end
    pause();
    chk({16'h0, oes}, 32'hffff);
    chk({16'h0, outs}, 32'hf6a6);
    bLow <= 4'h6;
    pause();
    rd(BPD_P0B_DAT_IDX, 32'h6);
    bLow <= 4'h0;
    aLow <= 4'h5;
    pause();
    rd(BPD_P0A_DAT_IDX, 32'hb);
    wr(BPD_P0A_DAT_IDX, rdat);
    aLow <= 4'h0;
    pause();
    chk({28'h0, portZeroAOut}, 32'hb);
    wr(BPD_P1A_DIR_IDX, 32'h3);
    pause();
    chk({28'h0, portOneAOe}, 32'h3);
    rd(BPD_P1A_DAT_IDX, 32'ha);
    dLow <= 4'h8;
    pause();
    rd(BPD_P1A_DAT_IDX, 32'h2);
    dLow <= 4'h0;
    wr(BPD_P1A_DAT_IDX, 32'hd);
    wr(BPD_P1A_DIR_IDX, 32'hf);
    pause();
    chk({28'h0, portOneAOut}, 32'hd);
    wr(BPD_CTRL_IDX, 32'h1);
    wr(BPD_CTRL_IDX, 32'h0);
    chk({16'h0, oes}, 32'h0);
    wr(BPD_P1A_DIR_IDX, 32'hf);
    pause();
    chk({28'h0, portOneAOut}, 32'hd);
    wr(BPD_CTRL_IDX, 32'h2);
    pause();
    chk({31'h0, inputGate}, 32'h1);
    rd(BPD_P0A_DAT_IDX, 32'h0);
    rd(BPD_P0C_DAT_IDX, 32'h5);
    wr(BPD_CTRL_IDX, 32'h0);
    wr(BPD_P1A_DIR_IDX, 32'hf);
    wr(BPD_CTRL_IDX, 32'h4);
    wr(BPD_P1A_DIR_IDX, 32'h0);
    wr(BPD_P1A_DAT_IDX, 32'h0);
    rd(BPD_P1A_DIR_IDX, 32'hf);
    chk({28'h0, portOneAOut}, 32'hd);
    wr(BPD_CTRL_IDX, 32'h0);
    xfer(1'b0, 8'h50, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    final_report();
  end
endmodule : bpd_port_test
bind bpd_port bpd_port_sva sva (.ref_clk, .nrst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .portOneAOut, .portOneAOe,
  .portZeroCOe, .inputGate);
